//--- rtl/usr_pkg.sv
package usr_pkg;
  // Register byte addresses; printed offsets are word indices
  localparam logic [3:0]  IDX_DATA     = 4'h0;
  localparam logic [3:0]  IDX_ERR      = 4'h1;
  localparam logic [3:0]  IDX_CTRL     = 4'h2;
  localparam logic [3:0]  IDX_BAUD     = 4'h3;
  localparam logic [3:0]  IDX_STATUS   = 4'h4;
  localparam logic [7:0]  ADDR_DATA    = {2'h0, IDX_DATA, 2'h0};
  localparam logic [7:0]  ADDR_ERR     = {2'h0, IDX_ERR, 2'h0};
  localparam logic [7:0]  ADDR_CTRL    = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [7:0]  ADDR_BAUD    = {2'h0, IDX_BAUD, 2'h0};
  localparam logic [7:0]  ADDR_STATUS  = {2'h0, IDX_STATUS, 2'h0};
  // Status bits
  localparam int ST_RXDONE = 15;
  localparam int ST_TXRDY  = 14;
  localparam int ST_RXFULL = 6;
  localparam int ST_BUSY   = 3;
  // Error flag bits
  localparam int EF_OVR = 3;
  localparam int EF_PAR = 1;
  localparam int EF_FRM = 0;
  // Control bits
  localparam int CT_RX_IRQ_EN   = 15;
  localparam int CT_TX_IRQ_EN   = 14;
  localparam int CT_RX_ENABLE   = 13;
  localparam int CT_TX_ENABLE   = 12;
  localparam int CT_TXSEL  = 10;
  localparam int CT_RXSEL  = 9;
  localparam int CT_STOP2  = 3;
  localparam int CT_PSEL   = 2;
  localparam int CT_PEN    = 1;
  localparam logic [15:0] CTRL_WMASK  = 16'hf60e;
  localparam logic [15:0] BAUD_RESET  = 16'h0000;
  localparam logic [15:0] TIMER_MAX   = 16'hffff;
  localparam logic [3:0]  OVS_LAST    = 4'hf;
  localparam logic [3:0]  OVS_MID     = 4'h7;
  localparam logic [3:0]  OVS_MID_LO  = 4'h6;
  localparam logic [3:0]  OVS_MID_HI  = 4'h8;
  localparam logic [1:0]  TXRDY_DLY   = 2'h2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [3:0]  NBITS       = 4'h8;

  typedef enum logic [2:0] {
    USR_IDLE  = 3'b000,
    USR_START = 3'b001,
    USR_DATA  = 3'b010,
    USR_PAR   = 3'b011,
    USR_STOP  = 3'b100,
    USR_STOP2 = 3'b101
  } usr_phase_t;
endpackage

//--- rtl/usr_tick.sv
`timescale 1ns/1ps
module usr_tick
  import usr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] baud,
  output logic             tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } usr_tick_st_t;
  usr_tick_st_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == TIMER_MAX) begin
      s_next.cnt  = baud;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

  property tick_period_p;
    @(posedge ref_clk) disable iff (rst)
      $rose(tick) && baud == 16'hfffe |-> ##2 tick;
  endproperty
  tick_period_a: assert property (tick_period_p)
    else $error("baud tick period wrong");
endmodule

//--- rtl/usr_sync.sv
`timescale 1ns/1ps
module usr_sync
  import usr_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } usr_sync_st_t;
  usr_sync_st_t s_reg, s_next;

  // Idle line is high, so reset to one avoids a false start edge
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = din;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.s2;
endmodule

//--- rtl/usr_uart.sv
`timescale 1ns/1ps
module usr_uart
  import usr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_in_a,
  input  wire logic        serial_in_b,
  output logic             serial_out_a,
  output logic             serial_out_b,
  output logic             irq
);
  typedef struct packed {
    logic             aw_ok;
    logic [7:0]       aw_addr;
    logic             w_ok;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             aw_rdy;
    logic             w_rdy;
    logic             ar_rdy;
    logic [15:0]      ctrl;
    logic [15:0]      baud;
    logic [3:0]       err_live;
    logic [3:0]       err_reg;
    logic             rx_done_flag;
    logic             tx_ready_flag;
    logic             rx_full_flag;
    logic             tx_busy_flag;
    logic [7:0]       rx_buf;
    logic             tx_pend;
    logic [7:0]       tx_buf;
    usr_phase_t       tx_ph;
    logic [3:0]       tx_div;
    logic [3:0]       tx_bit;
    logic [7:0]       tx_sh;
    logic             tx_line;
    logic [1:0]       tx_gap;
    usr_phase_t       rx_ph;
    logic [3:0]       rx_div;
    logic [3:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic [1:0]       vote;
    logic             rx_prev;
    logic             out_a;
    logic             out_b;
    logic             irq;
  } usr_st_t;
  usr_st_t s_reg, s_next;

  logic tick;
  logic rx_a;
  logic rx_b;

  usr_tick u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .baud    (s_reg.baud),
    .tick    (tick)
  );
  usr_sync u_sync_a (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (serial_in_a),
    .dout    (rx_a)
  );
  usr_sync u_sync_b (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (serial_in_b),
    .dout    (rx_b)
  );

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [3:0]  strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8],
               strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  logic        rx_line;
  logic        do_wr;
  logic        do_rd;
  logic        rd_data;
  logic        wr_data;
  logic [15:0] rd_val;
  logic        rx_bit_v;
  logic        par_even;

  always_comb begin
    s_next = s_reg;
    rx_line = s_reg.ctrl[CT_RXSEL] ? rx_a : rx_b;
    do_wr = s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid;
    do_rd = s_axi_arvalid && !s_reg.rvalid;
    rd_data = do_rd && s_axi_araddr == ADDR_DATA;
    wr_data = do_wr && s_reg.aw_addr == ADDR_DATA && s_reg.w_strb[0];
    rd_val = 16'h0000;
    rx_bit_v = 1'b0;
    par_even = s_reg.ctrl[CT_PSEL];

    // Write address and data latch independently, any order
    if (s_axi_awvalid && !s_reg.aw_ok) begin
      s_next.aw_ok   = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_ok) begin
      s_next.w_ok   = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end

    if (do_wr) begin
      s_next.aw_ok  = 1'b0;
      s_next.w_ok   = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      unique case (s_reg.aw_addr)
        ADDR_DATA: begin
          if (wr_data) begin
            s_next.tx_buf  = s_reg.w_data[7:0];
            s_next.tx_pend = 1'b1;
          end
        end
        ADDR_ERR: begin
          if (s_reg.w_strb[0]) begin
            s_next.err_reg = s_reg.err_reg & ~s_reg.w_data[3:0];
            s_next.err_live = s_reg.err_live & ~s_reg.w_data[3:0];
          end
        end
        ADDR_CTRL: begin
          s_next.ctrl = merge16(s_reg.ctrl, s_reg.w_data[15:0],
                                s_reg.w_strb) & CTRL_WMASK;
        end
        ADDR_BAUD: begin
          s_next.baud = merge16(s_reg.baud, s_reg.w_data[15:0],
                                s_reg.w_strb);
        end
        ADDR_STATUS: begin
          s_next.bresp = RESP_OKAY;
        end
        default: begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    if (do_rd) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        // Data port also mirrors the live error bits in its upper byte
        ADDR_DATA:   rd_val = {4'h0, s_reg.err_live, s_reg.rx_buf};
        ADDR_ERR:    rd_val = {12'h000, s_reg.err_reg};
        ADDR_CTRL:   rd_val = s_reg.ctrl;
        ADDR_BAUD:   rd_val = s_reg.baud;
        ADDR_STATUS: begin
          rd_val[ST_RXDONE] = s_reg.rx_done_flag;
          rd_val[ST_TXRDY]  = s_reg.tx_ready_flag;
          rd_val[ST_RXFULL] = s_reg.rx_full_flag;
          rd_val[ST_BUSY]   = s_reg.tx_busy_flag;
        end
        default: begin
          s_next.rresp = RESP_SLVERR;
        end
      endcase
      s_next.rdata = {16'h0000, rd_val};
    end

    if (rd_data) begin
      s_next.err_reg = s_reg.err_live;
      s_next.rx_done_flag = 1'b0;
      s_next.rx_full_flag = 1'b0;
    end

    // Transmitter
    if (wr_data) begin
      s_next.tx_ready_flag = 1'b0;
    end
    if (tick) begin
      s_next.tx_div = s_reg.tx_div + 4'h1;
    end
    if (tick && s_reg.tx_div == OVS_LAST) begin
      unique case (s_reg.tx_ph)
        USR_IDLE: begin
          if (s_reg.tx_pend && s_reg.ctrl[CT_TX_ENABLE]) begin
            s_next.tx_pend      = 1'b0;
            s_next.tx_sh        = s_reg.tx_buf;
            s_next.tx_line      = 1'b0;
            s_next.tx_ph        = USR_DATA;
            s_next.tx_bit       = 4'h0;
            s_next.tx_busy_flag = 1'b1;
          end
        end
        USR_DATA: begin
          s_next.tx_line = s_reg.tx_sh[0];
          s_next.tx_sh   = {1'b0, s_reg.tx_sh[7:1]};
          s_next.tx_bit  = s_reg.tx_bit + 4'h1;
          if (s_reg.tx_bit == NBITS - 4'h1) begin
            s_next.tx_ph = s_reg.ctrl[CT_PEN] ? USR_PAR : USR_STOP;
          end
        end
        USR_PAR: begin
          s_next.tx_line = ^s_reg.tx_buf ^ ~par_even;
          s_next.tx_ph   = USR_STOP;
        end
        USR_STOP: begin
          s_next.tx_line = 1'b1;
          s_next.tx_ph = s_reg.ctrl[CT_STOP2] ? USR_STOP2 : USR_START;
        end
        USR_STOP2: begin
          s_next.tx_ph = USR_START;
        end
        USR_START: begin
          // Last stop bit period has ended
          // Busy until stops sent
          s_next.tx_busy_flag = 1'b0;
          s_next.tx_ph        = USR_IDLE;
          s_next.tx_gap       = TXRDY_DLY;
        end
        default: s_next.tx_ph = USR_IDLE;
      endcase
    end
    if (s_reg.tx_gap != 2'h0) begin
      s_next.tx_gap = s_reg.tx_gap - 2'h1;
      if (s_reg.tx_gap == 2'h1 && !s_reg.tx_pend && !wr_data) begin
        s_next.tx_ready_flag = 1'b1;
      end
    end
    // Clearing the enable clears ready; a level test would
    // drop the reset value of one before software enables
    if (s_reg.ctrl[CT_TX_ENABLE] && !s_next.ctrl[CT_TX_ENABLE]) begin
      s_next.tx_ready_flag = 1'b0;
    end else if (s_reg.ctrl[CT_TX_ENABLE] && s_reg.tx_ph == USR_IDLE &&
                 !s_reg.tx_pend && !s_reg.tx_busy_flag &&
                 s_reg.tx_gap == 2'h0 && !wr_data) begin
      s_next.tx_ready_flag = 1'b1;
    end

    // Receiver
    s_next.rx_prev = rx_line;
    if (tick) begin
      s_next.rx_div = s_reg.rx_div + 4'h1;
      if (s_reg.rx_div == OVS_MID_LO) begin
        s_next.vote[0] = rx_line;
      end
      if (s_reg.rx_div == OVS_MID) begin
        s_next.vote[1] = rx_line;
      end
    end
    rx_bit_v = majority({rx_line, s_reg.vote});
    if (!s_reg.ctrl[CT_RX_ENABLE]) begin
      s_next.rx_ph = USR_IDLE;
      s_next.rx_done_flag = 1'b0;
    end else if (s_reg.rx_ph == USR_IDLE) begin
      if (s_reg.rx_prev && !rx_line) begin
        s_next.rx_ph  = USR_START;
        s_next.rx_div = 4'h0;
      end
    end else if (tick && s_reg.rx_div == OVS_MID_HI) begin
      unique case (s_reg.rx_ph)
        USR_START: begin
          s_next.rx_ph  = rx_bit_v ? USR_IDLE : USR_DATA;
          s_next.rx_bit = 4'h0;
        end
        USR_DATA: begin
          s_next.rx_sh  = {rx_bit_v, s_reg.rx_sh[7:1]};
          s_next.rx_bit = s_reg.rx_bit + 4'h1;
          if (s_reg.rx_bit == NBITS - 4'h1) begin
            s_next.rx_ph = s_reg.ctrl[CT_PEN] ? USR_PAR : USR_STOP;
          end
        end
        USR_PAR: begin
          s_next.err_live[EF_PAR] = (^s_reg.rx_sh ^ rx_bit_v) == par_even;
          s_next.rx_ph = USR_STOP;
        end
        USR_STOP: begin
          s_next.err_live[EF_FRM] = !rx_bit_v;
          s_next.err_live[EF_OVR] = s_reg.rx_full_flag && !rd_data;
          s_next.rx_buf       = s_reg.rx_sh;
          s_next.rx_done_flag = 1'b1;
          s_next.rx_full_flag = 1'b1;
          s_next.rx_ph        = USR_IDLE;
        end
        default: s_next.rx_ph = USR_IDLE;
      endcase
    end

    // Idle line high on both channels
    s_next.out_a = s_reg.ctrl[CT_TXSEL] ? s_reg.tx_line : 1'b1;
    s_next.out_b = s_reg.ctrl[CT_TXSEL] ? 1'b1 : s_reg.tx_line;
    // Readies from flops so no port is driven through logic
    s_next.aw_rdy = !s_next.aw_ok;
    s_next.w_rdy  = !s_next.w_ok;
    s_next.ar_rdy = !s_next.rvalid;
    s_next.irq = (s_reg.ctrl[CT_RX_IRQ_EN] && s_reg.rx_done_flag) ||
                 (s_reg.ctrl[CT_TX_IRQ_EN] && s_reg.tx_ready_flag);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg               <= '0;
      s_reg.baud          <= BAUD_RESET;
      s_reg.tx_line       <= 1'b1;
      s_reg.out_a         <= 1'b1;
      s_reg.out_b         <= 1'b1;
      s_reg.rx_prev       <= 1'b1;
      s_reg.tx_ready_flag <= 1'b1;
      s_reg.tx_ph         <= USR_IDLE;
      s_reg.rx_ph         <= USR_IDLE;
      s_reg.aw_rdy        <= 1'b1;
      s_reg.w_rdy         <= 1'b1;
      s_reg.ar_rdy        <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.aw_rdy;
  assign s_axi_wready  = s_reg.w_rdy;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.ar_rdy;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign serial_out_a  = s_reg.out_a;
  assign serial_out_b  = s_reg.out_b;
  assign irq           = s_reg.irq;

  busy_frame_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_reg.tx_ph != USR_IDLE |-> s_reg.tx_busy_flag)
    else $error("busy low during frame");
  sequence tx_end_s;
    $fell(s_reg.tx_busy_flag) ##0 s_reg.ctrl[CT_TX_ENABLE];
  endsequence
  // A write in the gap cycle legally holds ready low
  sequence gap_free_s;
    s_reg.ctrl[CT_TX_ENABLE] && !s_reg.tx_pend && !do_wr;
  endsequence
  ready_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
    tx_end_s ##1 gap_free_s |=> s_reg.tx_ready_flag)
    else $error("ready not two clocks after stop");
  ready_early_a: assert property (@(posedge ref_clk) disable iff (rst)
    tx_end_s |-> !s_reg.tx_ready_flag ##1 !s_reg.tx_ready_flag)
    else $error("ready rose before two clocks");
  done_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_data && !(tick && s_reg.rx_ph == USR_STOP) |=> !s_reg.rx_done_flag)
    else $error("done not cleared by read");
  ready_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_data |=> !s_reg.tx_ready_flag)
    else $error("ready not cleared by write");
  // Error register changes only on data read or clear
  err_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !rd_data && !do_wr |=> $stable(s_reg.err_reg))
    else $error("error register changed without read");
  full_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_reg.rx_done_flag) |-> s_reg.rx_full_flag)
    else $error("full flag not set with done");
  idle_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_reg.tx_ph == USR_IDLE && $past(s_reg.tx_ph == USR_IDLE, 1) |->
    s_reg.tx_line)
    else $error("tx line low while idle");
  start_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_reg.tx_busy_flag) |-> !s_reg.tx_line)
    else $error("start bit not low");
  irq_src_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_reg.ctrl[CT_RX_IRQ_EN] && s_reg.rx_done_flag |=> irq)
    else $error("irq missing");
endmodule

//--- testbench/usr_serial_dev.sv
`timescale 1ns/1ps
module usr_serial_dev #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic ref_clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] rx_byte;
  logic       rx_par;
  logic       rx_stop;
  initial line_out = 1'b1;
  task automatic hold(input logic v, input int n);
    line_out <= v;
    repeat (n) @(posedge ref_clk);
  endtask
  // Even parity bit; bp and bs break parity or stop on purpose
  task automatic send(input logic [7:0] d, input logic parity_on, input logic bp,
                      input logic bs);
    @(posedge ref_clk);
    hold(1'b0, BIT_CLKS);
    for (int i = 0; i < 8; i++) hold(d[i], BIT_CLKS);
    if (parity_on) hold(^d ^ bp, BIT_CLKS);
    hold(~bs, BIT_CLKS);
    hold(1'b1, BIT_CLKS);
  endtask
  // Short low pulse, far shorter than the centre of a bit
  task automatic glitch();
    @(posedge ref_clk);
    hold(1'b0, 4);
    hold(1'b1, 2 * BIT_CLKS);
  endtask
  // Samples at bit centres, measured from the start edge
  task automatic recv(input logic parity_on);
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge ref_clk);
      rx_byte[i] = line_in;
    end
    if (parity_on) begin
      repeat (BIT_CLKS) @(posedge ref_clk);
      rx_par = line_in;
    end
    repeat (BIT_CLKS) @(posedge ref_clk);
    rx_stop = line_in;
  endtask
endmodule

//--- testbench/usr_uart_tb.sv
`timescale 1ns/1ps
module usr_uart_tb;
  import usr_pkg::*;
  // Both enables, both channels on line a
  localparam logic [15:0] CFG = 16'h3600;
  logic        ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, serial_in_a;
  logic        serial_out_a, serial_out_b, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  int          num_errors = 0, n_tests = 0, cycles = 0;

  usr_uart u_usr_uart (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_in_a, .serial_in_b(1'b1), .serial_out_a, .serial_out_b, .irq);
  usr_serial_dev #(.BIT_CLKS(32)) u_usr_serial_dev (.ref_clk,
    .line_in(serial_out_a), .line_out(serial_in_a));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    // First baud tick comes a full timer wrap after reset
    if (cycles == 85000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds each channel until its own handshake edge
  task automatic axi(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int   t;
    logic done;
    t = 0;
    done = 1'b0;
    @(posedge ref_clk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!done && t < 100) begin
      @(posedge ref_clk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
    end
    last_resp = wr ? s_axi_bresp : s_axi_rresp;
    q = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!done) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    axi(1'b1, a, d);
    check({30'h0, last_resp}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    axi(1'b0, a, 16'h0000);
    check(q, exp);
  endtask

  task automatic t_reset();
    rd(ADDR_STATUS, 32'h0000_4000);
    rd(ADDR_ERR, 32'h0000_0000);
    axi(1'b0, 8'h14, 16'h0000);
    check({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
  endtask
  task automatic t_tx();
    logic [2:0] modes [4] = '{3'b000, 3'b011, 3'b101, 3'b100};
    logic [2:0] m;
    logic [7:0] d;
    wr(ADDR_BAUD, 16'hfffe);
    rd(ADDR_BAUD, 32'h0000_fffe);
    for (int i = 0; i < 4; i++) begin
      m = modes[i];
      d = 8'ha5 + 8'(i);
      wr(ADDR_CTRL, CFG | {12'h000, m, 1'b0});
      fork
        u_usr_serial_dev.recv(m[0]);
        begin
          wr(ADDR_DATA, {8'h00, d});
          axi(1'b0, ADDR_STATUS, 16'h0000);
          check(q & 32'h0000_4000, 32'h0);
        end
      join
      check({24'h0, u_usr_serial_dev.rx_byte}, {24'h0, d});
      check({31'h0, u_usr_serial_dev.rx_stop}, 32'h1);
      if (m[0])
        check({31'h0, u_usr_serial_dev.rx_par}, {31'h0, ^d ^ ~m[1]});
      rd(ADDR_STATUS, 32'h0000_0008);
      repeat (28) @(posedge ref_clk);
      rd(ADDR_STATUS, m[2] ? 32'h0000_0008 : 32'h0000_4000);
      check({31'h0, serial_out_b}, 32'h1);
    end
    $display("test transmit done");
  endtask
  task automatic t_rx();
    wr(ADDR_CTRL, CFG);
    u_usr_serial_dev.send(8'h3c, 1'b0, 1'b0, 1'b0);
    rd(ADDR_STATUS, 32'h0000_c040);
    rd(ADDR_DATA, 32'h0000_003c);
    rd(ADDR_STATUS, 32'h0000_4000);
    u_usr_serial_dev.send(8'h11, 1'b0, 1'b0, 1'b0);
    u_usr_serial_dev.send(8'h22, 1'b0, 1'b0, 1'b0);
    rd(ADDR_ERR, 32'h0000_0000);
    rd(ADDR_DATA, 32'h0000_0822);
    rd(ADDR_ERR, 32'h0000_0008);
    u_usr_serial_dev.send(8'h33, 1'b0, 1'b0, 1'b0);
    rd(ADDR_DATA, 32'h0000_0033);
    rd(ADDR_ERR, 32'h0000_0000);
    $display("test receive done");
  endtask
  task automatic t_errors();
    wr(ADDR_CTRL, CFG | 16'h0006);
    u_usr_serial_dev.send(8'h5a, 1'b1, 1'b1, 1'b0);
    rd(ADDR_DATA, 32'h0000_025a);
    rd(ADDR_ERR, 32'h0000_0002);
    u_usr_serial_dev.send(8'ha5, 1'b1, 1'b0, 1'b1);
    rd(ADDR_DATA, 32'h0000_01a5);
    rd(ADDR_ERR, 32'h0000_0001);
    wr(ADDR_ERR, 16'h0001);
    rd(ADDR_ERR, 32'h0000_0000);
    wr(ADDR_CTRL, CFG | 16'h0002);
    u_usr_serial_dev.send(8'h0f, 1'b1, 1'b1, 1'b0);
    rd(ADDR_DATA, 32'h0000_000f);
    $display("test errors done");
  endtask
  task automatic t_glitch();
    wr(ADDR_CTRL, CFG | 16'h8000);
    u_usr_serial_dev.glitch();
    u_usr_serial_dev.send(8'h81, 1'b0, 1'b0, 1'b0);
    rd(ADDR_DATA, 32'h0000_0081);
    u_usr_serial_dev.send(8'h42, 1'b0, 1'b0, 1'b0);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_CTRL, 16'h0000);
    axi(1'b0, ADDR_STATUS, 16'h0000);
    check(q & 32'h0000_c000, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test glitch done");
  endtask

  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h3;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_errors();
    t_glitch();
    end_sim();
  end
endmodule
